// >>> design/mmbd_top.sv
// Memory map top: program counter, fetch port, data port and AXI4-Lite slave
`timescale 1ns/1ps
// Behaviour
// - Separate fetch and data paths run concurrently
// - Thirteen-bit program counter, 8K-word space
// - Fetch above 07FFh wraps to low 11 bits
// - Reset starts fetch at address 0000h
// - Taken interrupt loads counter with 0004h
// - Status bits 6:5 select bank
// - Seven-bit offset, 128 bytes per bank
// - SFRs low, RAM 20h-7Fh and A0h-BFh
// - Core registers mirrored in banks 0 and 1 only
// - Direct or pointer-indirect access everywhere
module mmbd_top
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Fetch side
	input wire logic fetch_advance,
	input wire logic jump_en,
	input wire logic [10:0] jump_target,
	input wire logic intr_take,
	output logic [12:0] pc,
	output logic [13:0] instr,
	// Data side
	input wire mmbd_pkg::mmbd_dreq_t dreq,
	output mmbd_pkg::mmbd_drsp_t drsp,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [8:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// Program loading
	input wire logic load_en,
	input wire logic [10:0] load_addr,
	input wire logic [13:0] load_word,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****************************************************************
	// Core registers
	// ****************************************************************
	logic [12:0] pc_ff, nxt_pc;
	logic [7:0] status_ff, nxt_status;
	logic [7:0] pointer_ff, nxt_pointer;
	logic [7:0] program_counter_high_latch_ff, nxt_program_counter_high_latch;
	logic [7:0] interrupt_control_register_ff, nxt_interrupt_control_register;
	logic [7:0] ram [mmbd_pkg::RAM_DEPTH];
	logic halt_ff, nxt_halt;

	// ****************************************************************
	// Data port
	// ****************************************************************
	logic [8:0] full_addr;
	mmbd_pkg::mmbd_region_t region;
	logic [6:0] ram_index, core_offset;
	logic [7:0] core_rd;
	logic ram_we;
	mmbd_pkg::mmbd_drsp_t drsp_ff, nxt_drsp;
	logic sfr_wr_ff, nxt_sfr_wr, sfr_rd_ff, nxt_sfr_rd;
	logic [8:0] sfr_addr_ff, nxt_sfr_addr;
	logic [7:0] sfr_wdata_ff, nxt_sfr_wdata;
	logic sfr_pend_ff, nxt_sfr_pend;

	// ****************************************************************
	// Bus slave state
	// ****************************************************************
	logic aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
	logic [7:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic axi_wr;

	function automatic logic addr_known(input logic [7:0] a);
		return a == mmbd_pkg::AXI_CTRL || a == mmbd_pkg::AXI_PC || a == mmbd_pkg::AXI_STATUS
			|| a == mmbd_pkg::AXI_POINTER || a == mmbd_pkg::AXI_PC_LATCH;
	endfunction

	mmbd_decode u_decode
	(
		.indirect(dreq.indirect || dreq.offset == mmbd_pkg::OFS_INDIRECT),
		.offset(dreq.offset),
		.status(status_ff),
		.pointer(pointer_ff),
		.full_addr(full_addr),
		.region(region),
		.ram_index(ram_index),
		.core_offset(core_offset)
	);

	// Fetch runs on its own port, never stalled by data traffic
	mmbd_prog_mem u_prog
	(
		.aclk(aclk),
		.ce(ce),
		.fetch_addr(pc_ff),
		.fetch_word(instr),
		.load_en(load_en),
		.load_addr(load_addr),
		.load_word(load_word)
	);

	assign pc = pc_ff;
	assign drsp = drsp_ff;
	assign sfr_wr = sfr_wr_ff;
	assign sfr_rd = sfr_rd_ff;
	assign sfr_addr = sfr_addr_ff;
	assign sfr_wdata = sfr_wdata_ff;
	assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
	assign s_axi_wready = !w_ok_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	always_comb
	begin
		unique case (core_offset)
			mmbd_pkg::OFS_PC_LOW: core_rd = pc_ff[7:0];
			mmbd_pkg::OFS_STATUS: core_rd = status_ff;
			mmbd_pkg::OFS_POINTER: core_rd = pointer_ff;
			mmbd_pkg::OFS_PC_LATCH: core_rd = program_counter_high_latch_ff;
			mmbd_pkg::OFS_INT_CTRL: core_rd = interrupt_control_register_ff;
			default: core_rd = 8'h00; // Pointer at the window itself
		endcase
	end

	always_comb
	begin
		axi_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
		nxt_aw_ok = aw_ok_ff;
		nxt_w_ok = w_ok_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_aw_ok = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_w_ok = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (axi_wr)
		begin
			nxt_aw_ok = 1'b0;
			nxt_w_ok = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = addr_known(awaddr_ff) ? mmbd_pkg::RESP_OKAY : mmbd_pkg::RESP_SLVERR;
		end
		else if (bvalid_ff && s_axi_bready)
		begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp = addr_known(s_axi_araddr) ? mmbd_pkg::RESP_OKAY : mmbd_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				mmbd_pkg::AXI_CTRL: nxt_rdata = {31'h00000000, halt_ff};
				mmbd_pkg::AXI_PC: nxt_rdata = {19'h00000, pc_ff};
				mmbd_pkg::AXI_STATUS: nxt_rdata = {24'h000000, status_ff};
				mmbd_pkg::AXI_POINTER: nxt_rdata = {24'h000000, pointer_ff};
				mmbd_pkg::AXI_PC_LATCH: nxt_rdata = {24'h000000, program_counter_high_latch_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			nxt_rvalid = 1'b0;
		end
	end

	always_comb
	begin
		nxt_pc = pc_ff;
		nxt_status = status_ff;
		nxt_pointer = pointer_ff;
		nxt_program_counter_high_latch = program_counter_high_latch_ff;
		nxt_interrupt_control_register = interrupt_control_register_ff;
		nxt_halt = halt_ff;
		nxt_drsp = '0;
		nxt_sfr_wr = 1'b0;
		nxt_sfr_rd = 1'b0;
		nxt_sfr_addr = sfr_addr_ff;
		nxt_sfr_wdata = sfr_wdata_ff;
		nxt_sfr_pend = 1'b0;
		ram_we = 1'b0;
		// Fetch sequencing; interrupt outranks jump and step
		if (intr_take)
		begin
			nxt_pc = mmbd_pkg::INTR_VECTOR;
		end
		else if (jump_en)
		begin
			nxt_pc = {program_counter_high_latch_ff[4:3], jump_target};
		end
		else if (fetch_advance && !halt_ff)
		begin
			nxt_pc = 13'(pc_ff + 13'h0001);
		end
		// Peripheral read answers one cycle after it is issued
		if (sfr_pend_ff)
		begin
			nxt_drsp.valid = 1'b1;
			nxt_drsp.rdata = sfr_rdata;
		end
		if (dreq.valid)
		begin
			unique case (region)
				mmbd_pkg::REG_RAM:
				begin
					ram_we = dreq.write;
					nxt_drsp.valid = 1'b1;
					nxt_drsp.rdata = dreq.write ? 8'h00 : ram[ram_index];
				end
				mmbd_pkg::REG_CORE:
				begin
					nxt_drsp.valid = 1'b1;
					nxt_drsp.rdata = dreq.write ? 8'h00 : core_rd;
					if (dreq.write)
					begin
						unique case (core_offset)
							mmbd_pkg::OFS_PC_LOW: nxt_pc = {program_counter_high_latch_ff[4:0], dreq.wdata};
							mmbd_pkg::OFS_STATUS: nxt_status = dreq.wdata;
							mmbd_pkg::OFS_POINTER: nxt_pointer = dreq.wdata;
							mmbd_pkg::OFS_PC_LATCH: nxt_program_counter_high_latch = dreq.wdata;
							mmbd_pkg::OFS_INT_CTRL: nxt_interrupt_control_register = dreq.wdata;
							default: nxt_pointer = pointer_ff;
						endcase
					end
				end
				mmbd_pkg::REG_SFR:
				begin
					nxt_sfr_wr = dreq.write;
					nxt_sfr_rd = !dreq.write;
					nxt_sfr_addr = full_addr;
					nxt_sfr_wdata = dreq.wdata;
					nxt_sfr_pend = !dreq.write;
					nxt_drsp.valid = dreq.write;
				end
				default:
				begin
					nxt_drsp.valid = 1'b1;
					nxt_drsp.rdata = 8'h00;
				end
			endcase
		end
		// Debug writes from the bus win over core writes
		if (axi_wr && wstrb_ff[0])
		begin
			unique case (awaddr_ff)
				mmbd_pkg::AXI_CTRL: nxt_halt = wdata_ff[0];
				mmbd_pkg::AXI_STATUS: nxt_status = wdata_ff[7:0];
				mmbd_pkg::AXI_POINTER: nxt_pointer = wdata_ff[7:0];
				mmbd_pkg::AXI_PC_LATCH: nxt_program_counter_high_latch = wdata_ff[7:0];
				mmbd_pkg::AXI_PC: nxt_pc = wdata_ff[12:0];
				default: nxt_halt = halt_ff;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (ce && ram_we)
		begin
			ram[ram_index] <= dreq.wdata;
		end
		if (!aresetn)
		begin
			pc_ff <= mmbd_pkg::RESET_VECTOR;
			status_ff <= mmbd_pkg::RESET_STATUS;
			pointer_ff <= mmbd_pkg::RESET_ZERO;
			program_counter_high_latch_ff <= mmbd_pkg::RESET_ZERO;
			interrupt_control_register_ff <= mmbd_pkg::RESET_ZERO;
			halt_ff <= 1'b0;
			drsp_ff <= '0;
			sfr_wr_ff <= 1'b0;
			sfr_rd_ff <= 1'b0;
			sfr_addr_ff <= 9'h000;
			sfr_wdata_ff <= 8'h00;
			sfr_pend_ff <= 1'b0;
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= mmbd_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= mmbd_pkg::RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end
		else if (ce)
		begin
			pc_ff <= nxt_pc;
			status_ff <= nxt_status;
			pointer_ff <= nxt_pointer;
			program_counter_high_latch_ff <= nxt_program_counter_high_latch;
			interrupt_control_register_ff <= nxt_interrupt_control_register;
			halt_ff <= nxt_halt;
			drsp_ff <= nxt_drsp;
			sfr_wr_ff <= nxt_sfr_wr;
			sfr_rd_ff <= nxt_sfr_rd;
			sfr_addr_ff <= nxt_sfr_addr;
			sfr_wdata_ff <= nxt_sfr_wdata;
			sfr_pend_ff <= nxt_sfr_pend;
			aw_ok_ff <= nxt_aw_ok;
			w_ok_ff <= nxt_w_ok;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end
endmodule

// >>> design/mmbd_pkg.sv
// Shared constants and carrier types for the memory map and bank decode block
package mmbd_pkg;
	// ****************************************************************
	// Program memory
	// ****************************************************************
	localparam int PC_W = 13;
	localparam int IW_W = 14;
	localparam int PROG_AW = 11;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] INTR_VECTOR = 13'h0004;
	localparam logic [12:0] PROG_TOP = 13'h07ff;

	// ****************************************************************
	// Data memory map
	// ****************************************************************
	localparam int OFS_W = 7;
	localparam int DADDR_W = 9;
	localparam logic [6:0] OFS_INDIRECT = 7'h00;
	localparam logic [6:0] OFS_PC_LOW = 7'h02;
	localparam logic [6:0] OFS_STATUS = 7'h03;
	localparam logic [6:0] OFS_POINTER = 7'h04;
	localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
	localparam logic [6:0] OFS_INT_CTRL = 7'h0b;
	localparam logic [6:0] GPR0_LO = 7'h20;
	localparam logic [6:0] GPR1_LO = 7'h20;
	localparam logic [6:0] GPR1_HI = 7'h3f;
	localparam int STATUS_BANK_HI_BIT = 6;
	localparam int STATUS_BANK_LO_BIT = 5;
	localparam int STATUS_IRP_BIT = 7;
	localparam int RAM_DEPTH = 128;
	localparam logic [7:0] RESET_STATUS = 8'h18;
	localparam logic [7:0] RESET_ZERO = 8'h00;

	// ****************************************************************
	// AXI4-Lite register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] AXI_CTRL = 8'h00;
	localparam logic [7:0] AXI_PC = 8'h04;
	localparam logic [7:0] AXI_STATUS = 8'h08;
	localparam logic [7:0] AXI_POINTER = 8'h0c;
	localparam logic [7:0] AXI_PC_LATCH = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {REG_SFR, REG_RAM, REG_CORE, REG_NONE} mmbd_region_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic indirect;
		logic [6:0] offset;
		logic [7:0] wdata;
	} mmbd_dreq_t;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} mmbd_drsp_t;
endpackage

// >>> design/mmbd_decode.sv
// Data address decoder: bank join, indirect path and region routing
`timescale 1ns/1ps
module mmbd_decode
(
	// Access
	input wire logic indirect,
	input wire logic [6:0] offset,
	input wire logic [7:0] status,
	input wire logic [7:0] pointer,
	// Result
	output logic [8:0] full_addr,
	output mmbd_pkg::mmbd_region_t region,
	output logic [6:0] ram_index,
	output logic [6:0] core_offset
);
	logic [1:0] bank;
	logic [6:0] ofs;

	always_comb
	begin
		// Indirect takes the pointer and the IRP bit (status bit 7)
		if (indirect)
		begin
			full_addr = {status[mmbd_pkg::STATUS_IRP_BIT], pointer};
		end
		else
		begin
			full_addr = {status[mmbd_pkg::STATUS_BANK_HI_BIT], status[mmbd_pkg::STATUS_BANK_LO_BIT],
				offset};
		end
		bank = full_addr[8:7];
		ofs = full_addr[6:0];
		core_offset = ofs;
		ram_index = 7'h00;
		region = mmbd_pkg::REG_NONE;
		if (bank[1])
		begin
			region = mmbd_pkg::REG_NONE;
		end
		else if (ofs == mmbd_pkg::OFS_PC_LOW || ofs == mmbd_pkg::OFS_STATUS
			|| ofs == mmbd_pkg::OFS_POINTER || ofs == mmbd_pkg::OFS_PC_LATCH
			|| ofs == mmbd_pkg::OFS_INT_CTRL || ofs == mmbd_pkg::OFS_INDIRECT)
		begin
			region = mmbd_pkg::REG_CORE;
		end
		else if (!bank[0] && ofs >= mmbd_pkg::GPR0_LO)
		begin
			region = mmbd_pkg::REG_RAM;
			ram_index = ofs;
		end
		else if (bank[0] && ofs >= mmbd_pkg::GPR1_LO && ofs <= mmbd_pkg::GPR1_HI)
		begin
			region = mmbd_pkg::REG_RAM;
			ram_index = ofs - mmbd_pkg::GPR1_LO;
		end
		else if (ofs < mmbd_pkg::GPR0_LO)
		begin
			region = mmbd_pkg::REG_SFR;
		end
	end
endmodule

// >>> design/mmbd_prog_mem.sv
// Program store, 2K words, addressed by the low fetch bits
`timescale 1ns/1ps
module mmbd_prog_mem
#(
	parameter int DEPTH = 2048
)
(
	// Clock
	input wire logic aclk,
	input wire logic ce,
	// Fetch port
	input wire logic [12:0] fetch_addr,
	output logic [13:0] fetch_word,
	// Load port
	input wire logic load_en,
	input wire logic [10:0] load_addr,
	input wire logic [13:0] load_word
);
	logic [13:0] store [DEPTH];
	logic [13:0] nxt_word;
	logic [13:0] word_ff;

	assign fetch_word = word_ff;

	always_comb
	begin
		// Upper fetch bits are dropped so the map wraps
		nxt_word = store[fetch_addr[mmbd_pkg::PROG_AW-1:0]];
	end

	always_ff @(posedge aclk)
	begin
		if (ce)
		begin
			word_ff <= nxt_word;
			if (load_en)
			begin
				store[load_addr] <= load_word;
			end
		end
	end
endmodule

// >>> test/mmbd_checker.sv
// Port-level assertions for the memory map top
`timescale 1ns/1ps
module mmbd_checker
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Fetch side
	input wire logic jump_en,
	input wire logic [10:0] jump_target,
	input wire logic intr_take,
	input wire logic [12:0] pc,
	// Data side
	input wire mmbd_pkg::mmbd_dreq_t dreq,
	input wire mmbd_pkg::mmbd_drsp_t drsp,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [8:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_reset_vector: assert property ($rose(aresetn) |-> pc == 13'h0000)
		else $error("pc not at reset vector");
	a_intr_vector: assert property (ce && intr_take |=> pc == 13'h0004)
		else $error("interrupt did not load vector");
	a_jump_load: assert property (ce && jump_en && !intr_take |=> pc[10:0] == $past(jump_target))
		else $error("jump target not loaded");
	a_sfr_answer: assert property (sfr_rd |=> drsp.valid && drsp.rdata == $past(sfr_rdata))
		else $error("peripheral read not returned");
	a_answer_cause: assert property (drsp.valid |-> $past(dreq.valid) || $past(sfr_rd))
		else $error("answer without request");
	a_sfr_low_ofs: assert property (sfr_wr || sfr_rd |-> sfr_addr[6:0] < 7'h20)
		else $error("peripheral strobe in ram range");
	a_sfr_bank_impl: assert property (sfr_wr || sfr_rd |-> !sfr_addr[8])
		else $error("peripheral strobe in absent bank");
	a_sfr_wr_data: assert property (sfr_wr |-> sfr_wdata == $past(dreq.wdata) && $past(dreq.write))
		else $error("peripheral write data wrong");
	a_sfr_direct_ofs: assert property (sfr_rd && !$past(dreq.indirect) && $past(dreq.offset) != 7'h00
		|-> sfr_addr[6:0] == $past(dreq.offset))
		else $error("peripheral offset wrong");
endmodule

bind mmbd_top mmbd_checker u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce), .jump_en(jump_en),
	.jump_target(jump_target), .intr_take(intr_take), .pc(pc), .dreq(dreq), .drsp(drsp),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata));

// >>> test/mmbd_core_model.sv
// Core data-port model with a peripheral register responder
`timescale 1ns/1ps
module mmbd_core_model
(
	// Clock
	input wire logic aclk,
	// Data port
	output mmbd_pkg::mmbd_dreq_t dreq = '0,
	input wire mmbd_pkg::mmbd_drsp_t drsp,
	// Peripheral registers
	input wire logic sfr_rd,
	input wire logic [8:0] sfr_addr,
	output logic [7:0] sfr_rdata
);
	logic [7:0] pat_ff = 8'h00;
	always_ff @(posedge aclk) pat_ff <= pat_ff + 8'h01;
	// Unselected bus churns so a stale sample cannot pass
	assign sfr_rdata = sfr_rd ? (sfr_addr[7:0] ^ 8'h5a) : pat_ff;
	// One request, then idle until the answer
	task automatic dacc(input logic w, ind, input logic [6:0] o, input logic [7:0] wd,
		output logic [7:0] rd, output logic ok);
		ok = 1'b0;
		rd = 8'h00;
		@(posedge aclk);
		dreq <= '{1'b1, w, ind, o, wd};
		@(posedge aclk);
		dreq.valid <= 1'b0;
		for (int n = 0; n < 8 && !ok; n++)
		begin
			@(posedge aclk);
			ok = (drsp.valid === 1'b1);
			rd = drsp.rdata;
		end
	endtask
endmodule

// >>> test/mcu_memory_map_bank_decode_tb.sv
// Self-checking bench for the memory map and bank decode top
`timescale 1ns/1ps
module mcu_memory_map_bank_decode_tb;
	localparam logic [1:0] OK = mmbd_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = mmbd_pkg::RESP_SLVERR;
	localparam logic [7:0] A_ST = mmbd_pkg::AXI_STATUS;
	localparam logic [7:0] A_PTR = mmbd_pkg::AXI_POINTER;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, fetch_advance = 1'b0, jump_en = 1'b0;
	logic intr_take = 1'b0, load_en = 1'b0;
	logic [10:0] jump_target = 11'h000, load_addr = 11'h000;
	logic [13:0] load_word = 14'h0000;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [12:0] pc;
	wire logic [13:0] instr;
	wire logic sfr_wr, sfr_rd;
	wire logic [8:0] sfr_addr;
	wire logic [7:0] sfr_wdata, sfr_rdata;
	wire mmbd_pkg::mmbd_dreq_t dreq;
	wire mmbd_pkg::mmbd_drsp_t drsp;
	int miscompares = 0, cmp_count = 0;
	logic [7:0] rd;
	logic ok;
	logic [6:0] ofs [4] = '{7'h20, 7'h3f, 7'h40, 7'h7f};

	always #4 aclk = ~aclk;

	mmbd_top DUT (.aclk, .aresetn, .ce, .fetch_advance, .jump_en, .jump_target, .intr_take,
		.pc, .instr, .dreq, .drsp, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
		.load_en, .load_addr, .load_word, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	mmbd_core_model core (.aclk, .dreq, .drsp, .sfr_rd, .sfr_addr, .sfr_rdata);

	// ********
	// Tasks
	// ********
	task conclude;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task tmo;
		miscompares++;
		conclude;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) tmo;
		chk(s_axi_bresp, er);
	endtask
	task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) tmo;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
	endtask
	task dat(input logic w, ind, input logic [6:0] o, input logic [7:0] wd, ed);
		core.dacc(w, ind, o, wd, rd, ok);
		if (!ok) tmo;
		if (!w) chk(rd, ed);
	endtask

	// ********
	// Sequence
	// ********
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			load_en <= 1'b1;
			load_addr <= 11'(i);
			load_word <= 14'h1000 + 14'(i);
		end
		@(posedge aclk) load_en <= 1'b0;
		@(posedge aclk);
		chk(pc, 13'h0000);
		chk(instr, 14'h1000);
		axi_rd(A_ST, 32'(mmbd_pkg::RESET_STATUS), OK);
		axi_rd(8'h40, 32'h0, ERR);
		axi_wr(8'h40, 32'hff, ERR);
		s_axi_wstrb <= 4'h0;
		axi_wr(A_PTR, 32'h55, OK);
		s_axi_wstrb <= 4'h1;
		axi_rd(A_PTR, 32'h0, OK);
		$display("test reset done");
		axi_wr(mmbd_pkg::AXI_PC_LATCH, 32'h08, OK);
		@(posedge aclk) jump_en <= 1'b1;
		jump_target <= 11'h00c;
		@(posedge aclk) jump_en <= 1'b0;
		@(posedge aclk) chk(pc, 13'h080c);
		@(posedge aclk) chk(instr, 14'h100c);
		intr_take <= 1'b1;
		fetch_advance <= 1'b1;
		@(posedge aclk) intr_take <= 1'b0;
		@(posedge aclk) fetch_advance <= 1'b0;
		chk(pc, 13'h0004);
		@(posedge aclk) chk(pc, 13'h0005);
		chk(instr, 14'h1004);
		axi_rd(mmbd_pkg::AXI_PC, 32'h5, OK);
		$display("test fetch done");
		for (int b = 0; b < 4; b++)
		begin
			axi_wr(A_ST, 32'(b << 5), OK);
			for (int k = 0; k < 4; k++) dat(1'b1, 1'b0, ofs[k], 8'(16 * b + k + 1), 8'h00);
		end
		for (int b = 0; b < 4; b++)
		begin
			axi_wr(A_ST, 32'(b << 5), OK);
			for (int k = 0; k < 4; k++)
				dat(1'b0, 1'b0, ofs[k], 8'h00, (b == 0 || (b == 1 && k < 2)) ? 8'(16 * b + k + 1) : 8'h00);
		end
		$display("test banks done");
		axi_wr(A_ST, 32'h20, OK);
		dat(1'b1, 1'b0, mmbd_pkg::OFS_POINTER, 8'ha0, 8'h00);
		axi_rd(A_PTR, 32'ha0, OK);
		axi_wr(A_ST, 32'h00, OK);
		dat(1'b0, 1'b0, mmbd_pkg::OFS_POINTER, 8'h00, 8'ha0);
		dat(1'b0, 1'b0, mmbd_pkg::OFS_INDIRECT, 8'h00, 8'h11);
		dat(1'b0, 1'b1, 7'h55, 8'h00, 8'h11);
		dat(1'b1, 1'b1, 7'h00, 8'h77, 8'h00);
		dat(1'b0, 1'b1, 7'h00, 8'h00, 8'h77);
		dat(1'b0, 1'b0, 7'h20, 8'h00, 8'h01);
		axi_wr(A_PTR, 32'hd0, OK);
		dat(1'b0, 1'b1, 7'h00, 8'h00, 8'h00);
		axi_wr(A_PTR, 32'h85, OK);
		dat(1'b0, 1'b1, 7'h00, 8'h00, 8'hdf);
		dat(1'b0, 1'b0, 7'h05, 8'h00, 8'h5f);
		dat(1'b1, 1'b0, 7'h06, 8'h3c, 8'h00);
		$display("test mirror and pointer done");
		conclude;
	end
endmodule
